// ===== hdl/mdmtm_defs.vh
// Constants for the modem test mode controller: bus map, fields, reset values, timing.
// Assumes a 25 MHz clock and a classic Wishbone slave port with 32-bit data.
//
// Contract
// - Reset selects normal mode: line and terminal exchange data, both mode lamps off.
// - Each button press steps normal, remote loop, local terminal loop, local pattern loop.
// - Remote loop: decoded receive line data is sent straight back on the transmit line.
// - Remote loop: high mode lamp on, low mode lamp off.
// - Remote loop: terminal disabled; request and clear to send do not affect looped data.
// - Remote loop: carrier present indication works as in normal mode.
// - Remote loop: receive and transmit activity lamps held off.
// - Local terminal loop: terminal data looped to receiver, nothing sent to the line.
// - Local terminal loop: high mode lamp off, low mode lamp on.
// - Local terminal loop: carrier present lamp held off.
// - Local terminal loop: activity lamps show receive and transmit data.
// - Local terminal loop: data loops without request to send from the terminal.
// - Local pattern loop: internal alternating mark and space data, looped, kept off line.
// - The test pattern runs at 19,200 baud.
// - Local pattern loop: both mode lamps on; carrier lamp flashes while pattern received.
// - Local pattern loop: ignore request, clear to send and terminal data; receive lamp on.
// - Local pattern loop: terminal sees repeating character code 85.
// - Termination selections stay in effect in every mode.
// - Normal mode: terminal data sent only with request and clear to send both asserted.
`ifndef MDMTM_DEFS_VH
`define MDMTM_DEFS_VH

// ==========================================================
// Register map (byte addresses)
`define MDMTM_ADR_CTRL      8'h00
`define MDMTM_ADR_STATUS    8'h04

// CTRL fields
`define MDMTM_CTRL_STEP     0
`define MDMTM_CTRL_PAT_OFF  1
`define MDMTM_CTRL_RST      2'h0

// STATUS fields
`define MDMTM_ST_MODE_LO    0
`define MDMTM_ST_MODE_HI    1
`define MDMTM_ST_RTS        2
`define MDMTM_ST_CTS        3
`define MDMTM_ST_CARRIER    4
`define MDMTM_ST_PAT_OK     5

// Mode codes as shown in STATUS
`define MDMTM_MODE_NORMAL   2'h0
`define MDMTM_MODE_REMOTE   2'h1
`define MDMTM_MODE_LOC_TERM 2'h2
`define MDMTM_MODE_LOC_PAT  2'h3

// ==========================================================
// Timing
`define MDMTM_CLK_HZ        25000000
`define MDMTM_CLK_MHZ       25
`define MDMTM_PAT_BAUD      19200
`define MDMTM_DEB_TIME_US   10000
`define MDMTM_LAMP_TIME_US  100
`define MDMTM_BIT_CYC       (`MDMTM_CLK_HZ / `MDMTM_PAT_BAUD)
`define MDMTM_LAMP_CYC      (`MDMTM_CLK_MHZ * `MDMTM_LAMP_TIME_US)
`define MDMTM_BIT_TOL       64
`define MDMTM_BLINK_BIT     21

`endif

// ===== hdl/mdmtm_debounce.v
// Pushbutton debouncer: one pulse per settled press.
// Assumes the button input is already synchronous to clk_i, active high when pressed.
`default_nettype none

module mdmtm_debounce #(
  parameter integer STABLE_CYC = 250000
) (
  // Clock and reset
  input  wire clk_i,
  input  wire rst_i,
  // Button
  input  wire button_i,
  output reg  press_o
);

  reg        stable;
  reg [17:0] count;

  // ==========================================================
  // Settle filter
  // A level must hold for STABLE_CYC cycles before it counts, so contact bounce never
  // reaches the mode sequencer; only the released-to-pressed change makes a pulse.
  always @(posedge clk_i) begin
    if (rst_i) begin
      stable  <= 1'b0;
      count   <= 18'h00000;
      press_o <= 1'b0;
    end else begin
      press_o <= 1'b0;
      if (button_i == stable) begin
        count <= 18'h00000;
      end else if (count == STABLE_CYC[17:0] - 18'h00001) begin
        count   <= 18'h00000;
        stable  <= button_i;
        press_o <= button_i;
      end else begin
        count <= count + 18'h00001;
      end
    end
  end

endmodule // mdmtm_debounce

`default_nettype wire

// ===== hdl/mdmtm_top.v
// Modem test mode controller: mode sequencer, data routing, lamps and Wishbone registers.
// Assumes all pin inputs are synchronous to clk_i; line_rxd_i is the demodulated receive
// data, which in the local loop modes is this modem's own looped transmit signal.
`default_nettype none
`include "mdmtm_defs.vh"

module mdmtm_top #(
  parameter integer DEB_CYC = `MDMTM_CLK_MHZ * `MDMTM_DEB_TIME_US
) (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // Wishbone slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [7:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  // Front panel
  input  wire        mode_button_i,
  output reg         mode_lamp_high_o,
  output reg         mode_lamp_low_o,
  output reg         carrier_present_lamp_o,
  output reg         rts_lamp_o,
  output reg         cts_lamp_o,
  output reg         rx_lamp_o,
  output reg         tx_lamp_o,
  // Terminal equipment side
  input  wire        terminal_equipment_txd_i,
  input  wire        terminal_equipment_rts_i,
  output reg         terminal_equipment_rxd_o,
  output reg         terminal_equipment_cts_o,
  output reg         terminal_equipment_dcd_o,
  // Line side
  input  wire        line_rxd_i,
  input  wire        line_carrier_i,
  input  wire        rx_term_sel_i,
  input  wire        tx_term_sel_i,
  output reg         line_txd_o,
  output reg         line_tx_en_o,
  output reg         analog_loop_o,
  output reg         rx_term_en_o,
  output reg         tx_term_en_o
);

  localparam [3:0] ST_NORMAL   = 4'h1;
  localparam [3:0] ST_REMOTE   = 4'h2;
  localparam [3:0] ST_LOC_TERM = 4'h4;
  localparam [3:0] ST_LOC_PAT  = 4'h8;

  localparam integer BIT_CYC_N  = `MDMTM_BIT_CYC;
  localparam integer BIT_TOL_N  = `MDMTM_BIT_TOL;
  localparam integer LAMP_CYC_N = `MDMTM_LAMP_CYC;
  localparam [10:0]  BIT_CYC    = BIT_CYC_N[10:0];
  localparam [10:0]  BIT_TOL    = BIT_TOL_N[10:0];
  localparam [11:0]  LAMP_CYC   = LAMP_CYC_N[11:0];

  wire       press;
  reg  [3:0] state;
  reg  [3:0] next_state;
  reg        step_req;
  reg        pat_off;
  reg        cts;
  reg  [10:0] pat_cnt;
  reg        pat_bit;
  reg        rx_prev;
  reg  [11:0] edge_cnt;
  reg        pat_ok;
  reg  [21:0] blink;
  reg  [11:0] rx_hold;
  reg  [11:0] tx_hold;
  reg        next_txd;
  reg  [1:0] mode_code;
  wire       hit_ctrl;
  wire       hit_status;
  wire       bus_req;

  // ==========================================================
  // Button and mode sequencer
  mdmtm_debounce #(
    .STABLE_CYC (DEB_CYC)
  ) u_debounce (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .button_i (mode_button_i),
    .press_o  (press)
  );

  always @* begin
    case (state)
      ST_NORMAL:   next_state = ST_REMOTE;
      ST_REMOTE:   next_state = ST_LOC_TERM;
      ST_LOC_TERM: next_state = ST_LOC_PAT;
      ST_LOC_PAT:  next_state = ST_NORMAL;
      default:     next_state = ST_NORMAL;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_NORMAL;
    end else if (press || step_req) begin
      state <= next_state;
    end
  end

  always @* begin
    case (state)
      ST_REMOTE:   mode_code = `MDMTM_MODE_REMOTE;
      ST_LOC_TERM: mode_code = `MDMTM_MODE_LOC_TERM;
      ST_LOC_PAT:  mode_code = `MDMTM_MODE_LOC_PAT;
      default:     mode_code = `MDMTM_MODE_NORMAL;
    endcase
  end

  // ==========================================================
  // Wishbone slave
  // One wait state: ack rises the cycle after the strobe and drops the cycle after.
  assign bus_req    = cyc_i && stb_i && !ack_o;
  assign hit_ctrl   = (adr_i == `MDMTM_ADR_CTRL);
  assign hit_status = (adr_i == `MDMTM_ADR_STATUS);

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o    <= 1'b0;
      dat_o    <= 32'h00000000;
      step_req <= 1'b0;
      pat_off  <= 1'b0;
    end else begin
      ack_o    <= bus_req;
      step_req <= 1'b0;
      dat_o    <= 32'h00000000;
      if (bus_req && we_i && hit_ctrl && sel_i[0]) begin
        step_req <= dat_i[`MDMTM_CTRL_STEP];
        pat_off  <= dat_i[`MDMTM_CTRL_PAT_OFF];
      end
      if (bus_req && !we_i && hit_ctrl) begin
        dat_o[`MDMTM_CTRL_PAT_OFF] <= pat_off;
      end
      if (bus_req && !we_i && hit_status) begin
        dat_o[`MDMTM_ST_MODE_HI:`MDMTM_ST_MODE_LO] <= mode_code;
        dat_o[`MDMTM_ST_RTS]     <= terminal_equipment_rts_i;
        dat_o[`MDMTM_ST_CTS]     <= cts;
        dat_o[`MDMTM_ST_CARRIER] <= line_carrier_i;
        dat_o[`MDMTM_ST_PAT_OK]  <= pat_ok;
      end
    end
  end

  // ==========================================================
  // Test pattern generator
  // Toggles every bit time; 8N1 framing of alternating bits reads as code 85 ('U').
  // The CTRL freeze bit holds the pattern at mark, a way to see the carrier lamp stop.
  always @(posedge clk_i) begin
    if (rst_i || state != ST_LOC_PAT) begin
      pat_cnt <= 11'h000;
      pat_bit <= 1'b1;
    end else if (pat_cnt == BIT_CYC - 11'h001) begin
      pat_cnt <= 11'h000;
      pat_bit <= pat_off ? 1'b1 : !pat_bit;
    end else begin
      pat_cnt <= pat_cnt + 11'h001;
    end
  end

  // ==========================================================
  // Pattern checker
  // An edge spaced one bit time apart (within tolerance) marks good reception; silence
  // for two bit times clears it.
  always @(posedge clk_i) begin
    if (rst_i || state != ST_LOC_PAT) begin
      rx_prev  <= 1'b1;
      edge_cnt <= 12'h000;
      pat_ok   <= 1'b0;
    end else begin
      rx_prev <= line_rxd_i;
      if (rx_prev != line_rxd_i) begin
        edge_cnt <= 12'h000;
        pat_ok   <= (edge_cnt >= {1'b0, BIT_CYC - BIT_TOL}) &&
                    (edge_cnt <= {1'b0, BIT_CYC + BIT_TOL});
      end else if (edge_cnt == {BIT_CYC, 1'b0}) begin
        pat_ok <= 1'b0;
      end else begin
        edge_cnt <= edge_cnt + 12'h001;
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      blink <= 22'h000000;
    end else begin
      blink <= blink + 22'h000001;
    end
  end

  // ==========================================================
  // Activity stretchers
  // A space bit reloads the hold so short characters stay visible on the lamps.
  always @(posedge clk_i) begin
    if (rst_i) begin
      rx_hold <= 12'h000;
      tx_hold <= 12'h000;
    end else begin
      if (!line_rxd_i) begin
        rx_hold <= LAMP_CYC;
      end else if (rx_hold != 12'h000) begin
        rx_hold <= rx_hold - 12'h001;
      end
      if (!next_txd) begin
        tx_hold <= LAMP_CYC;
      end else if (tx_hold != 12'h000) begin
        tx_hold <= tx_hold - 12'h001;
      end
    end
  end

  // ==========================================================
  // Transmit source select
  always @* begin
    case (state)
      ST_NORMAL:   next_txd = (terminal_equipment_rts_i && cts) ?
                              terminal_equipment_txd_i : 1'b1;
      ST_REMOTE:   next_txd = line_rxd_i;
      ST_LOC_TERM: next_txd = terminal_equipment_txd_i;
      ST_LOC_PAT:  next_txd = pat_bit;
      default:     next_txd = 1'b1;
    endcase
  end

  // ==========================================================
  // Registered outputs
  always @(posedge clk_i) begin
    if (rst_i) begin
      line_txd_o               <= 1'b1;
      line_tx_en_o             <= 1'b0;
      analog_loop_o            <= 1'b0;
      terminal_equipment_rxd_o <= 1'b1;
      terminal_equipment_cts_o <= 1'b0;
      terminal_equipment_dcd_o <= 1'b0;
      cts                      <= 1'b0;
      mode_lamp_high_o         <= 1'b0;
      mode_lamp_low_o          <= 1'b0;
      carrier_present_lamp_o   <= 1'b0;
      rts_lamp_o               <= 1'b0;
      cts_lamp_o               <= 1'b0;
      rx_lamp_o                <= 1'b0;
      tx_lamp_o                <= 1'b0;
      rx_term_en_o             <= 1'b0;
      tx_term_en_o             <= 1'b0;
    end else begin
      rx_term_en_o <= rx_term_sel_i;
      tx_term_en_o <= tx_term_sel_i;
      cts          <= terminal_equipment_rts_i && (state == ST_NORMAL);
      terminal_equipment_cts_o <= cts;
      rts_lamp_o   <= terminal_equipment_rts_i;
      cts_lamp_o   <= cts;
      line_txd_o   <= next_txd;
      case (state)
        ST_NORMAL: begin
          line_tx_en_o             <= cts;
          analog_loop_o            <= 1'b0;
          terminal_equipment_rxd_o <= line_rxd_i;
          terminal_equipment_dcd_o <= line_carrier_i;
          mode_lamp_high_o         <= 1'b0;
          mode_lamp_low_o          <= 1'b0;
          carrier_present_lamp_o   <= line_carrier_i;
          rx_lamp_o                <= (rx_hold != 12'h000);
          tx_lamp_o                <= (tx_hold != 12'h000);
        end
        ST_REMOTE: begin
          line_tx_en_o             <= 1'b1;
          analog_loop_o            <= 1'b0;
          terminal_equipment_rxd_o <= 1'b1;
          terminal_equipment_dcd_o <= 1'b0;
          mode_lamp_high_o         <= 1'b1;
          mode_lamp_low_o          <= 1'b0;
          carrier_present_lamp_o   <= line_carrier_i;
          rx_lamp_o                <= 1'b0;
          tx_lamp_o                <= 1'b0;
        end
        ST_LOC_TERM: begin
          line_tx_en_o             <= 1'b0;
          analog_loop_o            <= 1'b1;
          terminal_equipment_rxd_o <= line_rxd_i;
          terminal_equipment_dcd_o <= 1'b0;
          mode_lamp_high_o         <= 1'b0;
          mode_lamp_low_o          <= 1'b1;
          carrier_present_lamp_o   <= 1'b0;
          rx_lamp_o                <= (rx_hold != 12'h000);
          tx_lamp_o                <= (tx_hold != 12'h000);
        end
        ST_LOC_PAT: begin
          line_tx_en_o             <= 1'b0;
          analog_loop_o            <= 1'b1;
          terminal_equipment_rxd_o <= line_rxd_i;
          terminal_equipment_dcd_o <= 1'b0;
          mode_lamp_high_o         <= 1'b1;
          mode_lamp_low_o          <= 1'b1;
          carrier_present_lamp_o   <= pat_ok && blink[`MDMTM_BLINK_BIT];
          rx_lamp_o                <= 1'b1;
          // Terminal activity is only displayed here, never transmitted
          tx_lamp_o                <= !terminal_equipment_txd_i;
        end
        default: begin
          line_tx_en_o             <= 1'b0;
          analog_loop_o            <= 1'b0;
          terminal_equipment_rxd_o <= 1'b1;
          terminal_equipment_dcd_o <= 1'b0;
          mode_lamp_high_o         <= 1'b0;
          mode_lamp_low_o          <= 1'b0;
          carrier_present_lamp_o   <= 1'b0;
          rx_lamp_o                <= 1'b0;
          tx_lamp_o                <= 1'b0;
        end
      endcase
    end
  end

endmodule // mdmtm_top

`default_nettype wire

// ===== bench/mdmtm_sva.sv
// Checker for the modem test mode controller: bus answer, routing, lamps, pattern timing.
// Bound to mdmtm_top and sees its ports only; mode is read back from the mode lamps.
`default_nettype none
module mdmtm_sva (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus and panel
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic mode_lamp_high_o,
  input wire logic mode_lamp_low_o,
  input wire logic carrier_present_lamp_o,
  input wire logic rx_lamp_o,
  // Terminal and line
  input wire logic terminal_equipment_rts_i,
  input wire logic terminal_equipment_cts_o,
  input wire logic line_rxd_i,
  input wire logic line_carrier_i,
  input wire logic line_txd_o,
  input wire logic line_tx_en_o,
  input wire logic analog_loop_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic        normal, remote, term, pat, prev, tog;
  logic [1:0]  seen;
  logic [10:0] cnt;
  assign normal = ~mode_lamp_high_o & ~mode_lamp_low_o;
  assign remote = mode_lamp_high_o & ~mode_lamp_low_o;
  assign term   = ~mode_lamp_high_o & mode_lamp_low_o;
  assign pat    = mode_lamp_high_o & mode_lamp_low_o;
  assign tog    = line_txd_o != prev;
  // ==========================================
  // Bit timer; the first change after entry is not a full bit, so two are skipped
  always @(posedge clk_i) begin
    prev <= line_txd_o;
    cnt  <= tog ? 11'h000 : cnt + 11'h001;
    seen <= !pat ? 2'h0 : (seen == 2'h2 ? seen : seen + {1'b0, tog});
  end
  // ==========================================
  ack_after_take_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("bus request not answered next cycle");
  ack_single_a: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  reset_normal_a: assert property ($fell(rst_i) |-> normal && line_txd_o)
    else $error("not in normal mode after reset");
  remote_echo_a: assert property (remote |-> line_txd_o == $past(line_rxd_i) && line_tx_en_o)
    else $error("remote loop does not echo receive data");
  remote_quiet_a: assert property (remote && $past(remote) |-> !rx_lamp_o && !terminal_equipment_cts_o)
    else $error("terminal or lamps active in remote loop");
  remote_carrier_a: assert property (remote |-> carrier_present_lamp_o == $past(line_carrier_i))
    else $error("carrier lamp wrong in remote loop");
  term_loop_a: assert property (term |-> analog_loop_o && !line_tx_en_o && !carrier_present_lamp_o)
    else $error("terminal loop not isolated");
  pat_loop_a: assert property (pat |-> analog_loop_o && !line_tx_en_o && rx_lamp_o)
    else $error("pattern loop not isolated");
  pat_rate_a: assert property (pat && seen == 2'h2 && tog |-> cnt == 11'h515)
    else $error("pattern bit length wrong");
  normal_gate_a: assert property (normal && !line_txd_o |->
    $past(terminal_equipment_rts_i) && $past(terminal_equipment_rts_i, 2))
    else $error("data sent without request and clear to send");
  remote_c: cover property (remote && line_carrier_i);
  pat_bit_c: cover property (pat && seen == 2'h2 && tog);
  term_c: cover property (term && !line_txd_o);
endmodule // mdmtm_sva

bind mdmtm_top mdmtm_sva i_sva (.*);
`default_nettype wire

// ===== bench/mdmtm_far.sv
// Far side model: remote line modem plus the analog loop switch on the line.
// Assumes the bench drives the remote data and carrier on rising edges.
`default_nettype none
module mdmtm_far (
  // Clock
  input  wire logic clk_i,
  // From the device and the bench
  input  wire logic line_txd_i,
  input  wire logic analog_loop_i,
  input  wire logic rem_dat_i,
  input  wire logic rem_car_i,
  // To the device
  output var  logic line_rxd_o,
  output var  logic line_carrier_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial line_rxd_o = 1'b1;
  initial line_carrier_o = 1'b0;
  // Without carrier the demodulator output is noise, so it changes every cycle
  always @(posedge clk_i) begin
    line_carrier_o <= analog_loop_i | rem_car_i;
    if (analog_loop_i) line_rxd_o <= line_txd_i;
    else if (rem_car_i) line_rxd_o <= rem_dat_i;
    else line_rxd_o <= ~line_rxd_o;
  end
endmodule // mdmtm_far
`default_nettype wire

// ===== bench/modem_test_mode_controller_test.sv
// Testbench for mdmtm_top: steps through all modes by button and register writes.
// Assumes the far side model and the bound checker; debounce shortened to 4 cycles.
`default_nettype none
`include "mdmtm_defs.vh"
module modem_test_mode_controller_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, mode_button_i = 0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'hf;
  logic [31:0] dat_i = 32'h0, dat_o, q;
  logic ack_o, mode_lamp_high_o, mode_lamp_low_o, carrier_present_lamp_o, rts_lamp_o, cts_lamp_o;
  logic rx_lamp_o, tx_lamp_o, terminal_equipment_rxd_o, terminal_equipment_cts_o, terminal_equipment_dcd_o;
  logic terminal_equipment_txd_i = 1, terminal_equipment_rts_i = 0, rx_term_sel_i = 0, tx_term_sel_i = 0;
  logic line_rxd_i, line_carrier_i, line_txd_o, line_tx_en_o, analog_loop_o, rx_term_en_o, tx_term_en_o;
  logic rem_dat = 1, rem_car = 0;
  logic [7:0] ch;
  int miscompares = 0, check_count = 0, cycles = 0, n;
  always #20 clk_i = ~clk_i;
  mdmtm_top #(.DEB_CYC(4)) i_dut (.*);
  mdmtm_far i_far (.clk_i(clk_i), .line_txd_i(line_txd_o), .analog_loop_i(analog_loop_o),
    .rem_dat_i(rem_dat), .rem_car_i(rem_car), .line_rxd_o(line_rxd_i), .line_carrier_o(line_carrier_i));
  // ==========================================
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    q = dat_o;
    chk("ack", 1, ack_o);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i} <= 3'b000;
  endtask
  task wait_chk(input int c);
    repeat (c) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task mode_is(input logic [1:0] m);
    wb(0, `MDMTM_ADR_STATUS, 32'h0);
    chk("mode", m, q[1:0]);
    chk("mode lamps", {m[0], m[1]}, {mode_lamp_high_o, mode_lamp_low_o});
  endtask
  task step;
    wb(1, `MDMTM_ADR_CTRL, 32'h1);
    repeat (4) @(posedge clk_i);
  endtask
  task press(input int c);
    mode_button_i <= 1;
    repeat (c) @(posedge clk_i);
    mode_button_i <= 0;
    repeat (8) @(posedge clk_i);
  endtask
  task close_out;
    $display("checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ==========================================
  task t_normal;
    @(posedge clk_i);
    terminal_equipment_txd_i <= 0;
    wait_chk(4);
    chk("line txd", 1, line_txd_o);
    @(posedge clk_i);
    terminal_equipment_rts_i <= 1;
    wait_chk(4);
    chk("line txd", 0, line_txd_o);
    chk("cts", 1, terminal_equipment_cts_o);
    chk("rts cts lamps", 2'b11, {rts_lamp_o, cts_lamp_o});
    chk("tx lamp", 1, tx_lamp_o);
    wb(0, 8'h08, 32'h0);
    chk("unmapped read", 0, q);
    wb(0, `MDMTM_ADR_STATUS, 32'h0);
    chk("status rts", 1, q[2]);
    terminal_equipment_txd_i <= 1;
    $display("test normal done");
  endtask
  task t_remote;
    press(2);
    mode_is(0);
    press(6);
    mode_is(1);
    {rem_car, rem_dat} <= 2'b10;
    wait_chk(3);
    chk("line txd", 0, line_txd_o);
    chk("carrier lamp", 1, carrier_present_lamp_o);
    chk("term rxd", 1, terminal_equipment_rxd_o);
    chk("cts", 0, terminal_equipment_cts_o);
    chk("dcd", 0, terminal_equipment_dcd_o);
    @(posedge clk_i);
    {rem_car, rem_dat} <= 2'b01;
    $display("test remote done");
  endtask
  task t_term;
    step;
    mode_is(2);
    terminal_equipment_rts_i <= 0;
    terminal_equipment_txd_i <= 0;
    wait_chk(6);
    chk("line txd", 0, line_txd_o);
    chk("tx enable", 0, line_tx_en_o);
    chk("term rxd", 0, terminal_equipment_rxd_o);
    chk("activity lamps", 2'b11, {rx_lamp_o, tx_lamp_o});
    $display("test local terminal done");
  endtask
  task t_pattern;
    step;
    mode_is(3);
    rx_term_sel_i <= 1;
    tx_term_sel_i <= 1;
    n = 0;
    while (terminal_equipment_rxd_o !== 1'b1 && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    while (terminal_equipment_rxd_o !== 1'b0 && n < 6000) begin
      @(negedge clk_i);
      n++;
    end
    repeat (`MDMTM_BIT_CYC / 2) @(negedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (`MDMTM_BIT_CYC) @(negedge clk_i);
      ch[i] = terminal_equipment_rxd_o;
    end
    chk("pattern char", 8'h55, ch);
    chk("rx term", 1, rx_term_en_o);
    chk("tx term", 1, tx_term_en_o);
    wb(0, `MDMTM_ADR_STATUS, 32'h0);
    chk("pattern good", 1, q[5]);
    // Freeze holds mark; with no edges for two bit times the good flag must drop
    wb(1, `MDMTM_ADR_CTRL, 32'h2);
    repeat (3 * `MDMTM_BIT_CYC + 16) @(posedge clk_i);
    wb(0, `MDMTM_ADR_CTRL, 32'h0);
    chk("freeze readback", 32'h2, q);
    wb(0, `MDMTM_ADR_STATUS, 32'h0);
    chk("pattern stopped", 0, q[5]);
    step;
    mode_is(0);
    $display("test pattern done");
  endtask
  // ==========================================
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    wait_chk(1);
    chk("lamps", 0, {mode_lamp_high_o, mode_lamp_low_o});
    chk("line txd", 1, line_txd_o);
    t_normal;
    t_remote;
    t_term;
    t_pattern;
    close_out;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      close_out;
    end
  end
endmodule // modem_test_mode_controller_test
`default_nettype wire
